//--- src/card_deact_pkg.sv
// card session control: shared constants and types
// assumes a single 20 MHz clock and oscillator ticks derived from it
package card_deact_pkg;

  // system clock
  localparam int CLK_HZ = 20_000_000;
  // internal oscillator rates, plain defaults
  localparam int OSC_LOW_HZ = 140_000;
  localparam int OSC_HIGH_HZ = 2_500_000;

  // sequencing unit T in oscillator periods
  localparam int T_OSC = 64;
  localparam int SEQ_W = 7;
  localparam int DEB_W = 10;
  localparam int DIV_W = 16;

  // deactivation offsets in oscillator periods
  localparam logic [SEQ_W-1:0] RST_FALL_TICKS = SEQ_W'(3 * T_OSC / 64);
  localparam logic [SEQ_W-1:0] CLK_STOP_TICKS = SEQ_W'(T_OSC / 2);
  localparam logic [SEQ_W-1:0] LINES_LOW_TICKS = SEQ_W'(T_OSC);
  localparam logic [SEQ_W-1:0] SUPPLY_OFF_TICKS = SEQ_W'(3 * T_OSC / 2);

  // presence debounce in slow oscillator periods
  localparam logic [DEB_W-1:0] DEBOUNCE_TICKS = DEB_W'(640);

  typedef enum logic [1:0] {
    VCC_1V8,
    VCC_3V,
    VCC_5V
  } supply_level_t;

  typedef enum logic [2:0] {
    ST_SHUTDOWN,
    ST_DEEP,
    ST_ACTIVE,
    ST_DEACT_RST,
    ST_DEACT_STEPS,
    ST_WAIT_LOW
  } seq_state_t;

endpackage

//--- src/card_session_deactivation_control.sv
// card session control: deactivation, faults, presence, chip select
// assumes all inputs synchronous to clk; fault inputs are comparator levels
`timescale 1ns/10ps
module card_session_deactivation_control
  import card_deact_pkg::*;
#(
  parameter int LOW_DIV = CLK_HZ / OSC_LOW_HZ,
  parameter int HIGH_DIV = CLK_HZ / OSC_HIGH_HZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic chipSelect,
  input wire logic sessionRequestN,
  input wire logic hostResetIn,
  input wire logic clockDividerSelect,
  input wire logic supplySelectFirst,
  input wire logic supplySelectSecond,
  input wire logic cardPresentIn,
  input wire logic supplyOvercurrent,
  input wire logic overTemperature,
  input wire logic coreSupplyLow,
  input wire logic sourceSupplyLow,
  input wire logic hostSupplyLow,
  input wire logic supplyBelowMin,
  output logic cardResetOut,
  output logic cardClockRun,
  output logic cardLinesLow,
  output logic supplyEnable,
  output supply_level_t supplyLevel,
  output logic contactsGrounded,
  output logic oscFastMode,
  output logic cardStatus,
  output logic cardStatusEn,
  output logic hostLinesEn,
  output logic clockDividerHeld,
  output logic internalPorPulse,
  output logic deepShutdown
);

  typedef struct packed {
    seq_state_t state;
    logic [SEQ_W-1:0] seqCnt;
    logic [DEB_W-1:0] debCnt;
    logic presentDeb;
    logic presentPrev;
    logic heldReset;
    logic heldSessN;
    logic heldClkDiv;
    logic heldSel1;
    logic heldSel2;
    logic cardReset;
    logic clockRun;
    logic linesLow;
    logic supplyOn;
    logic contactsGnd;
    logic oscFast;
    logic status;
    logic statusEn;
    logic hostEn;
    logic porPulse;
    logic deep;
    supply_level_t level;
  } ctl_t;

  localparam ctl_t CTL_RST = '{
    state: ST_SHUTDOWN,
    seqCnt: '0,
    debCnt: '0,
    presentDeb: 1'b0,
    presentPrev: 1'b0,
    heldReset: 1'b0,
    heldSessN: 1'b1,
    heldClkDiv: 1'b0,
    // selects start high so reset alone never enters deep shutdown
    heldSel1: 1'b1,
    heldSel2: 1'b1,
    cardReset: 1'b0,
    clockRun: 1'b0,
    linesLow: 1'b1,
    supplyOn: 1'b0,
    contactsGnd: 1'b1,
    oscFast: 1'b0,
    status: 1'b0,
    statusEn: 1'b0,
    hostEn: 1'b0,
    porPulse: 1'b0,
    deep: 1'b0,
    level: VCC_1V8
  };

  ctl_t ctl_q, ctl_d;
  logic slowTick;
  logic modeTick;
  logic removal;
  logic railFault;
  logic powerFault;
  logic [SEQ_W-1:0] seqInc;

  osc_ticks #(
    .LOW_DIV(LOW_DIV),
    .HIGH_DIV(HIGH_DIV)
  ) uOsc (
    .clk(clk),
    .rst(rst),
    .fastMode(ctl_q.oscFast),
    .slowTick(slowTick),
    .modeTick(modeTick)
  );

  assign removal = ctl_q.presentPrev & ~cardPresentIn;
  assign railFault = coreSupplyLow | sourceSupplyLow | hostSupplyLow;
  assign powerFault = ctl_q.supplyOn & (supplyOvercurrent | overTemperature);
  assign seqInc = ctl_q.seqCnt + 1'b1;

  always_comb begin
    ctl_d = ctl_q;
    ctl_d.porPulse = 1'b0;
    ctl_d.presentPrev = cardPresentIn;
    if (chipSelect) begin
      ctl_d.heldReset = hostResetIn;
      ctl_d.heldSessN = sessionRequestN;
      ctl_d.heldClkDiv = clockDividerSelect;
      ctl_d.heldSel1 = supplySelectFirst;
      ctl_d.heldSel2 = supplySelectSecond;
    end
    ctl_d.statusEn = chipSelect;
    if (!ctl_q.heldSel1) begin
      ctl_d.level = VCC_1V8;
    end else if (ctl_q.heldSel2) begin
      ctl_d.level = VCC_5V;
    end else begin
      ctl_d.level = VCC_3V;
    end
    if (!cardPresentIn) begin
      ctl_d.presentDeb = 1'b0;
      ctl_d.debCnt = '0;
    end else if (!ctl_q.presentDeb && slowTick) begin
      if (ctl_q.debCnt == DEBOUNCE_TICKS - 1'b1) begin
        ctl_d.presentDeb = 1'b1;
        ctl_d.debCnt = '0;
      end else begin
        ctl_d.debCnt = ctl_q.debCnt + 1'b1;
      end
    end
    if (modeTick) begin
      ctl_d.seqCnt = seqInc;
    end
    unique case (ctl_q.state)
      ST_SHUTDOWN: begin
        ctl_d.status = ctl_q.presentDeb;
        ctl_d.oscFast = 1'b0;
        // idle rail drop pulses reset only
        ctl_d.porPulse = railFault;
        if (!ctl_q.heldSessN && ctl_q.presentDeb && !railFault) begin
          ctl_d.state = ST_ACTIVE;
          ctl_d.supplyOn = 1'b1;
          ctl_d.contactsGnd = 1'b0;
          ctl_d.oscFast = 1'b1;
          ctl_d.clockRun = 1'b1;
          ctl_d.linesLow = 1'b0;
          ctl_d.status = 1'b1;
        end else if (ctl_q.heldSessN && !ctl_q.heldSel1 &&
                     !ctl_q.heldSel2) begin
          ctl_d.state = ST_DEEP;
        end
      end
      ST_DEEP: begin
        // status follows presence, exit on session request or either select high
        ctl_d.status = cardPresentIn;
        ctl_d.porPulse = railFault;
        if (!ctl_q.heldSessN || ctl_q.heldSel1 || ctl_q.heldSel2) begin
          ctl_d.state = ST_SHUTDOWN;
        end
      end
      ST_ACTIVE: begin
        ctl_d.cardReset = ctl_q.heldReset;
        if (removal || railFault || powerFault) begin
          ctl_d.status = 1'b0;
          ctl_d.state = ST_DEACT_RST;
          ctl_d.seqCnt = '0;
        end else if (ctl_q.heldSessN) begin
          ctl_d.state = ST_DEACT_RST;
          ctl_d.seqCnt = '0;
        end
      end
      ST_DEACT_RST: begin
        if (modeTick && seqInc == RST_FALL_TICKS) begin
          ctl_d.cardReset = 1'b0;
          ctl_d.seqCnt = '0;
          ctl_d.state = ST_DEACT_STEPS;
        end
      end
      ST_DEACT_STEPS: begin
        if (modeTick && seqInc == CLK_STOP_TICKS) begin
          ctl_d.clockRun = 1'b0;
        end
        if (modeTick && seqInc == LINES_LOW_TICKS) begin
          ctl_d.linesLow = 1'b1;
        end
        if (modeTick && seqInc == SUPPLY_OFF_TICKS) begin
          ctl_d.supplyOn = 1'b0;
          ctl_d.state = ST_WAIT_LOW;
        end
      end
      ST_WAIT_LOW: begin
        if (supplyBelowMin) begin
          ctl_d.contactsGnd = 1'b1;
          ctl_d.oscFast = 1'b0;
          ctl_d.status = ctl_q.presentDeb;
          ctl_d.state = ST_SHUTDOWN;
        end
      end
      default: begin
        ctl_d = CTL_RST;
      end
    endcase
    // host lines pass only when selected in session
    ctl_d.hostEn = chipSelect && (ctl_d.state == ST_ACTIVE);
    ctl_d.deep = (ctl_d.state == ST_DEEP);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_q <= CTL_RST;
    end else begin
      ctl_q <= ctl_d;
    end
  end

  assign cardResetOut = ctl_q.cardReset;
  assign cardClockRun = ctl_q.clockRun;
  assign cardLinesLow = ctl_q.linesLow;
  assign supplyEnable = ctl_q.supplyOn;
  assign supplyLevel = ctl_q.level;
  assign contactsGrounded = ctl_q.contactsGnd;
  assign oscFastMode = ctl_q.oscFast;
  assign cardStatus = ctl_q.status;
  assign cardStatusEn = ctl_q.statusEn;
  assign hostLinesEn = ctl_q.hostEn;
  assign clockDividerHeld = ctl_q.heldClkDiv;
  assign internalPorPulse = ctl_q.porPulse;
  assign deepShutdown = ctl_q.deep;

  default clocking cbMain @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence seqRelease;
    ctl_q.state == ST_ACTIVE && ctl_q.heldSessN;
  endsequence

  sequence seqSessionFault;
    ctl_q.state == ST_ACTIVE && (removal || railFault || powerFault);
  endsequence

  AST_RELEASE_DEACT: assert property (
    seqRelease |=> ctl_q.state == ST_DEACT_RST && ctl_q.seqCnt == '0)
    else $error("release did not start deactivation");

  AST_CLOCK_AFTER_RESET: assert property (
    $fell(ctl_q.clockRun) |-> !ctl_q.cardReset)
    else $error("clock stopped before reset fell");

  AST_SUPPLY_AFTER_LINES: assert property (
    $fell(ctl_q.supplyOn) |-> ctl_q.linesLow && !ctl_q.clockRun)
    else $error("supply dropped before lines and clock");

  AST_RESET_OFFSET: assert property (
    ctl_q.state == ST_DEACT_RST && modeTick &&
    ctl_q.seqCnt == RST_FALL_TICKS - 1'b1
    |=> !ctl_q.cardReset && ctl_q.state == ST_DEACT_STEPS)
    else $error("reset fall offset wrong");

  AST_SUPPLY_OFFSET: assert property (
    $fell(ctl_q.supplyOn)
    |-> $past(ctl_q.state) == ST_DEACT_STEPS && $past(modeTick) &&
    $past(ctl_q.seqCnt) == SUPPLY_OFF_TICKS - 1'b1)
    else $error("supply off offset wrong");

  AST_GROUND_SLOW: assert property (
    ctl_q.state == ST_WAIT_LOW && supplyBelowMin
    |=> ctl_q.contactsGnd && !ctl_q.oscFast && ctl_q.state == ST_SHUTDOWN)
    else $error("contacts not grounded or oscillator fast");

  AST_IDLE_RAIL: assert property (
    ctl_q.state == ST_SHUTDOWN && railFault && ctl_q.heldSessN
    |=> ctl_q.porPulse && ctl_q.status == $past(ctl_q.presentDeb))
    else $error("idle rail drop mishandled");

  AST_FAULT_STATUS: assert property (
    seqSessionFault |=> !ctl_q.status ##1 ctl_q.state != ST_ACTIVE)
    else $error("session fault did not drop status");

  AST_DESELECT_FLOAT: assert property (
    !chipSelect |=> !cardStatusEn && !hostLinesEn)
    else $error("deselect did not float outputs");

  AST_FROZEN: assert property (
    !chipSelect |=> $stable(ctl_q.heldSessN) && $stable(ctl_q.heldReset))
    else $error("held inputs changed while deselected");

  AST_DEEP_FOLLOW: assert property (
    ctl_q.state == ST_DEEP ##1 ctl_q.state == ST_DEEP
    |-> ctl_q.status == $past(cardPresentIn))
    else $error("deep status not following presence");

  AST_DECODE: assert property (
    !$past(ctl_q.heldSel1) |-> supplyLevel == VCC_1V8)
    else $error("supply decode wrong");

endmodule

//--- src/osc_ticks.sv
// internal oscillator model: slow and current-mode tick pulses
// assumes clk is the system clock; ticks are one-cycle pulses
`timescale 1ns/10ps
module osc_ticks
  import card_deact_pkg::*;
#(
  parameter int LOW_DIV = CLK_HZ / OSC_LOW_HZ,
  parameter int HIGH_DIV = CLK_HZ / OSC_HIGH_HZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic fastMode,
  output logic slowTick,
  output logic modeTick
);

  generate
    if (HIGH_DIV < 1 || LOW_DIV < HIGH_DIV || LOW_DIV >= (1 << DIV_W)) begin : gBad
      $error("osc_ticks: divider out of range");
    end
  endgenerate

  localparam logic [DIV_W-1:0] LOW_LAST = DIV_W'(LOW_DIV - 1);
  localparam logic [DIV_W-1:0] HIGH_LAST = DIV_W'(HIGH_DIV - 1);

  typedef struct packed {
    logic [DIV_W-1:0] slowCnt;
    logic [DIV_W-1:0] fastCnt;
    logic slowTick;
    logic fastTick;
  } osc_t;

  osc_t osc_q, osc_d;

  always_comb begin
    osc_d = osc_q;
    osc_d.slowTick = 1'b0;
    osc_d.fastTick = 1'b0;
    if (osc_q.slowCnt == LOW_LAST) begin
      osc_d.slowCnt = '0;
      osc_d.slowTick = 1'b1;
    end else begin
      osc_d.slowCnt = osc_q.slowCnt + 1'b1;
    end
    if (osc_q.fastCnt == HIGH_LAST) begin
      osc_d.fastCnt = '0;
      osc_d.fastTick = 1'b1;
    end else begin
      osc_d.fastCnt = osc_q.fastCnt + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_q <= '0;
    end else begin
      osc_q <= osc_d;
    end
  end

  assign slowTick = osc_q.slowTick;
  // fast/slow selection of the sequencing tick
  assign modeTick = fastMode ? osc_q.fastTick : osc_q.slowTick;

endmodule

//--- tb/host_model.sv
// host controller model driving the session command pins
// assumes commands change one small delay after the clock edge
`timescale 1ns/10ps
module host_model (
  input wire logic clk,
  output logic chipSelect,
  output logic sessionRequestN,
  output logic hostResetIn,
  output logic clockDividerSelect,
  output logic supplySelectFirst,
  output logic supplySelectSecond
);
  initial begin
    chipSelect = 1'b1;
    sessionRequestN = 1'b1;
    hostResetIn = 1'b0;
    clockDividerSelect = 1'b0;
    supplySelectFirst = 1'b1;
    supplySelectSecond = 1'b1;
  end
  task automatic setSession(input logic sn, input logic hr);
    @(posedge clk);
    #1;
    sessionRequestN = sn;
    hostResetIn = hr;
  endtask
  task automatic setSelect(input logic cs, input logic dv);
    @(posedge clk);
    #1;
    chipSelect = cs;
    clockDividerSelect = dv;
  endtask
  task automatic setSupply(input logic s1, input logic s2);
    @(posedge clk);
    #1;
    supplySelectFirst = s1;
    supplySelectSecond = s2;
  endtask
endmodule

//--- tb/test_card_session_deactivation_control.sv
// self-checking bench for the card session control block
// assumes host_model drives command pins; bench drives card side
`timescale 1ns/10ps
module test_card_session_deactivation_control;
  import card_deact_pkg::*;
  localparam int LDIV = 4;
  localparam int HDIV = 2;
  logic clk, rst, cardPresentIn, supplyBelowMin;
  logic [4:0] flt;
  logic chipSelect, sessionRequestN, hostResetIn, clockDividerSelect;
  logic supplySelectFirst, supplySelectSecond;
  logic cardResetOut, cardClockRun, cardLinesLow, supplyEnable;
  logic contactsGrounded, oscFastMode, cardStatus, cardStatusEn;
  logic hostLinesEn, clockDividerHeld, internalPorPulse, deepShutdown;
  supply_level_t supplyLevel;
  int failCount, checks;

  host_model host (.clk, .chipSelect, .sessionRequestN, .hostResetIn,
    .clockDividerSelect, .supplySelectFirst, .supplySelectSecond);

  card_session_deactivation_control #(.LOW_DIV(LDIV), .HIGH_DIV(HDIV)) dut (
    .clk, .rst, .chipSelect, .sessionRequestN, .hostResetIn,
    .clockDividerSelect, .supplySelectFirst, .supplySelectSecond,
    .cardPresentIn, .supplyOvercurrent(flt[0]), .overTemperature(flt[1]),
    .coreSupplyLow(flt[2]), .sourceSupplyLow(flt[3]),
    .hostSupplyLow(flt[4]), .supplyBelowMin, .cardResetOut, .cardClockRun,
    .cardLinesLow, .supplyEnable, .supplyLevel, .contactsGrounded,
    .oscFastMode, .cardStatus, .cardStatusEn, .hostLinesEn,
    .clockDividerHeld, .internalPorPulse, .deepShutdown);

  task automatic chk(input logic [1:0] got, input logic [1:0] exp,
    input string msg);
    checks++;
    if (got !== exp) begin
      $display("ERROR at %0t: %s", $time, msg);
      failCount++;
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic cur(input int s);
    case (s)
      0: return supplyEnable;
      1: return cardStatus;
      2: return contactsGrounded;
      default: return internalPorPulse;
    endcase
  endfunction
  task automatic waitFor(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (cur(s) !== v && n < lim) begin
      step(1);
      n++;
    end
  endtask
  task automatic startCheck();
    waitFor(0, 1'b1, 10);
    chk(supplyEnable, 1'b1, "session start");
    chk(oscFastMode, 1'b1, "fast osc in session");
    supplyBelowMin = 1'b0;
  endtask
  task automatic endDeact();
    waitFor(0, 1'b0, 400);
    chk(supplyEnable, 1'b0, "supply off");
    chk(contactsGrounded, 1'b0, "contacts before low vcc");
    supplyBelowMin = 1'b1;
    waitFor(2, 1'b1, 4);
    chk(contactsGrounded, 1'b1, "contacts grounded");
    chk(oscFastMode, 1'b0, "osc back to slow");
  endtask

  task automatic testReset();
    chk(cardStatus, 1'b0, "status with no card");
    chk(contactsGrounded, 1'b1, "idle contacts");
    chk(oscFastMode, 1'b0, "idle osc slow");
    $display("test reset done");
  endtask
  task automatic testDebounce();
    int n;
    cardPresentIn = 1'b1;
    step(100);
    cardPresentIn = 1'b0;
    step(1);
    chk(cardStatus, 1'b0, "status during bounce");
    cardPresentIn = 1'b1;
    n = 0;
    while (cardStatus !== 1'b1 && n < 3000) begin
      step(1);
      n++;
    end
    chk(n >= 639 * LDIV && n <= 640 * LDIV + 3, 1'b1, "debounce");
    chk(cardStatus, 1'b1, "status with card");
    $display("test debounce done");
  endtask
  task automatic testRelease();
    int t, tr, tc, tl, ts;
    host.setSession(1'b0, 1'b1);
    startCheck();
    step(2);
    chk(cardResetOut, 1'b1, "reset follows host");
    host.setSession(1'b1, 1'b1);
    tr = 0;
    tc = 0;
    tl = 0;
    ts = 0;
    for (t = 1; t < 400 && ts == 0; t++) begin
      step(1);
      if (tr == 0 && cardResetOut === 1'b0) tr = t;
      if (tc == 0 && cardClockRun === 1'b0) tc = t;
      if (tl == 0 && cardLinesLow === 1'b1) tl = t;
      if (ts == 0 && supplyEnable === 1'b0) ts = t;
    end
    chk(tr >= 2 && tr <= 3 * HDIV + 6, 1'b1, "reset fall");
    chk(tc - tr == 32 * HDIV, 1'b1, "clock stop");
    chk(tl - tr == 64 * HDIV, 1'b1, "lines low");
    chk(ts - tr == 96 * HDIV, 1'b1, "supply off");
    endDeact();
    $display("test release done");
  endtask
  task automatic testChipSelect();
    host.setSelect(1'b0, 1'b1);
    host.setSession(1'b0, 1'b0);
    step(5);
    chk(cardStatusEn, 1'b0, "status floats");
    chk(hostLinesEn, 1'b0, "host lines isolated");
    chk(supplyEnable, 1'b0, "frozen request");
    chk(clockDividerHeld, 1'b0, "frozen divider");
    host.setSelect(1'b1, 1'b1);
    startCheck();
    chk(clockDividerHeld, 1'b1, "divider loads");
    chk(hostLinesEn, 1'b1, "host lines pass");
    chk(cardStatusEn, 1'b1, "status driven");
    host.setSelect(1'b0, 1'b1);
    host.setSession(1'b1, 1'b0);
    step(20);
    chk(supplyEnable, 1'b1, "release frozen");
    chk(cardClockRun, 1'b1, "clock runs deselected");
    host.setSelect(1'b1, 1'b0);
    endDeact();
    $display("test chip select done");
  endtask
  task automatic testIdle();
    int i;
    for (i = 2; i < 5; i++) begin
      flt[i] = 1'b1;
      waitFor(3, 1'b1, 3);
      chk(internalPorPulse, 1'b1, "idle reset pulse");
      chk(cardStatus, 1'b1, "status kept");
      flt[i] = 1'b0;
      step(2);
    end
    flt[1:0] = 2'b11;
    step(4);
    chk(cardStatus, 1'b1, "unpowered faults ignored");
    chk(internalPorPulse, 1'b0, "no pulse unpowered");
    flt = '0;
    step(1);
    $display("test idle done");
  endtask
  task automatic testFaults();
    int i;
    for (i = 0; i < 6; i++) begin
      host.setSession(1'b0, 1'b0);
      startCheck();
      step(3);
      if (i < 5) flt[i] = 1'b1;
      else cardPresentIn = 1'b0;
      waitFor(1, 1'b0, 2);
      chk(cardStatus, 1'b0, "fault drops status");
      waitFor(0, 1'b0, 400);
      chk(supplyEnable, 1'b0, "emergency deactivation");
      flt = '0;
      host.setSession(1'b1, 1'b0);
      endDeact();
    end
    $display("test faults done");
  endtask
  task automatic testDeep();
    int i;
    supply_level_t exp [4] = '{VCC_1V8, VCC_1V8, VCC_3V, VCC_5V};
    for (i = 3; i >= 0; i--) begin
      host.setSupply(i[1], i[0]);
      step(3);
      chk(supplyLevel, exp[i], "supply decode");
      chk(deepShutdown, i == 0, "deep only at both low");
    end
    cardPresentIn = 1'b1;
    step(2);
    chk(cardStatus, 1'b1, "deep status follows");
    cardPresentIn = 1'b0;
    step(2);
    chk(cardStatus, 1'b0, "deep status follows");
    host.setSupply(1'b1, 1'b0);
    step(3);
    chk(deepShutdown, 1'b0, "deep exit");
    $display("test deep done");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    cardPresentIn = 1'b0;
    supplyBelowMin = 1'b1;
    flt = '0;
    failCount = 0;
    checks = 0;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    step(2);
    testReset();
    testDebounce();
    testRelease();
    testChipSelect();
    testIdle();
    testFaults();
    testDeep();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    $display("ERROR at %0t: watchdog expired", $time);
    conclude();
  end
endmodule
